// ==== msfm_pkg.sv ====
// Package of constants and types for the mode strap function mapper
`default_nettype none
package msfm_pkg;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MSFM_MODE_4HOST   = 3'h0,
        MSFM_MODE_OTG     = 3'h1,
        MSFM_MODE_OTG_ISA = 3'h2,
        MSFM_MODE_OTG_GP  = 3'h3,
        MSFM_MODE_INVALID = 3'h7
    } msfm_mode_t;

    // ----------------------------------------------------------------
    // Function targets
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MSFM_FN_OHCI   = 3'h0,
        MSFM_FN_EHCI   = 3'h1,
        MSFM_FN_OTG    = 3'h2,
        MSFM_FN_ISA    = 3'h3,
        MSFM_FN_GPIO   = 3'h4,
        MSFM_FN_UNUSED = 3'h7
    } msfm_fn_t;

    // Pin pattern {test, sel2, sel1, sel0, otgLow}
    localparam logic [4:0] MSFM_PAT_4HOST   = 5'h01;
    localparam logic [4:0] MSFM_PAT_OTG     = 5'h02;
    localparam logic [4:0] MSFM_PAT_OTG_ISA = 5'h04;
    localparam logic [4:0] MSFM_PAT_OTG_GP  = 5'h06;

    localparam int MSFM_NUM_FUNC  = 8;
    localparam int MSFM_NUM_STRAP = 6;
    localparam int MSFM_SYNC_LEN  = 2;

    // Strap bit positions in the sampled vector
    localparam int MSFM_STRAP_ERRMASK = 0;
    localparam int MSFM_STRAP_RDSIZE  = 1;
    localparam int MSFM_STRAP_AUXPWR  = 2;
    localparam int MSFM_STRAP_ASPM    = 3;
    localparam int MSFM_STRAP_AER     = 4;
    localparam int MSFM_STRAP_HIBWAKE = 5;

    // Reset values: internal pull defaults (pulls down on link pins, up on GP pins)
    localparam logic [5:0] MSFM_STRAP_RESET = 6'h38;
    localparam logic [4:0] MSFM_PINS_RESET  = 5'h01;

    localparam logic [7:0] MSFM_RDSIZE_LIMIT = 8'h80;

    // APB register offsets and fields
    localparam logic [11:0] MSFM_REG_MODE   = 12'h000;
    localparam logic [11:0] MSFM_REG_STRAP  = 12'h004;
    localparam logic [11:0] MSFM_REG_FUNC   = 12'h008;
    localparam logic [11:0] MSFM_REG_CTRL   = 12'h00c;
    localparam int          MSFM_MODE_VALID_BIT = 8;
    localparam int          MSFM_CTRL_RELATCH   = 0;
    localparam logic [31:0] MSFM_CTRL_RESET     = 32'h0;

endpackage
`default_nettype wire

// ==== msfm_sync.sv ====
// Two flip-flop synchroniser for a vector of pin inputs
`default_nettype none
module msfm_sync #(
    parameter int        WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= INIT;
            pinOut <= INIT;
        end
        else
        begin
            meta_q <= pinIn;
            pinOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== msfm_func_map.sv ====
// Function-to-controller lookup for one function slot
`default_nettype none
module msfm_func_map #(
    parameter int FUNC = 0
) (
    // Mode in, target out
    input  wire msfm_pkg::msfm_mode_t mode,
    output msfm_pkg::msfm_fn_t        target,
    output logic [1:0]                channel
);
    always_comb
    begin
        target  = msfm_pkg::MSFM_FN_UNUSED;
        channel = 2'h0;
        if (FUNC < 6)
        begin
            // Even slots OHCI, odd EHCI, channel is slot/2
            target  = (FUNC % 2 == 0) ? msfm_pkg::MSFM_FN_OHCI : msfm_pkg::MSFM_FN_EHCI;
            channel = 2'(FUNC / 2);
        end
        else
        begin
            case (mode)
                msfm_pkg::MSFM_MODE_4HOST:
                begin
                    target  = (FUNC == 6) ? msfm_pkg::MSFM_FN_OHCI : msfm_pkg::MSFM_FN_EHCI;
                    channel = 2'h3;
                end
                msfm_pkg::MSFM_MODE_OTG, msfm_pkg::MSFM_MODE_OTG_ISA, msfm_pkg::MSFM_MODE_OTG_GP:
                begin
                    if (FUNC == 6)
                    begin
                        target  = msfm_pkg::MSFM_FN_OTG;
                        channel = 2'h2;
                    end
                    else if (mode == msfm_pkg::MSFM_MODE_OTG_ISA)
                        target = msfm_pkg::MSFM_FN_ISA;
                    else if (mode == msfm_pkg::MSFM_MODE_OTG_GP)
                        target = msfm_pkg::MSFM_FN_GPIO;
                    else
                        target = msfm_pkg::MSFM_FN_UNUSED;
                end
                default:
                begin
                    target  = msfm_pkg::MSFM_FN_UNUSED;
                    channel = 2'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== msfm_top.sv ====
// Mode strap function mapper: pin sampling, mode decode, strap outputs, APB view
`default_nettype none
module msfm_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Mode select pins
    input  wire logic        testEnable,
    input  wire logic        mode_pick_bit0,
    input  wire logic        mode_pick_bit1,
    input  wire logic        mode_pick_bit2,
    input  wire logic        otg_select_low,
    // Bootstrap pins
    input  wire logic        link_status_pin0,
    input  wire logic        link_status_pin1,
    input  wire logic        link_status_pin2,
    input  wire logic        gp_pin_19,
    input  wire logic        gp_pin_20,
    input  wire logic        gp_pin_21,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Configuration outputs
    output logic      [2:0]  opMode,
    output logic             modeValid,
    output logic      [23:0] funcTarget,
    output logic      [15:0] funcChannel,
    output logic             pcieErrMask,
    output logic             readSizeLimit,
    output logic      [7:0]  readSizeMax,
    output logic             auxPowerPresent,
    output logic             aspmEnable,
    output logic             aerEnable,
    output logic             d3ColdWakeEnable,
    output logic             latched
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] modePinsSync;
    logic [5:0] strapPinsSync;

    msfm_sync #(
        .WIDTH (5),
        .INIT  (msfm_pkg::MSFM_PINS_RESET)
    ) u_mode_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  ({testEnable, mode_pick_bit2, mode_pick_bit1, mode_pick_bit0, otg_select_low}),
        .pinOut (modePinsSync)
    );

    msfm_sync #(
        .WIDTH (6),
        .INIT  (msfm_pkg::MSFM_STRAP_RESET)
    ) u_strap_sync (
        .clk    (clk),
        .rst    (rst),
        .pinIn  ({gp_pin_21, gp_pin_20, gp_pin_19, link_status_pin2, link_status_pin1, link_status_pin0}),
        .pinOut (strapPinsSync)
    );

    // ----------------------------------------------------------------
    // Latch window
    // ----------------------------------------------------------------
    // Sampling waits for the synchronisers to fill with post-reset pin levels
    logic [1:0] settle_q;
    logic       latched_q;
    logic       relatch_q;
    logic       sampleNow;

    assign sampleNow = !latched_q && (settle_q == 2'(msfm_pkg::MSFM_SYNC_LEN));

    always_ff @(posedge clk)
    begin
        if (rst || relatch_q)
            settle_q <= 2'h0;
        else if (settle_q != 2'(msfm_pkg::MSFM_SYNC_LEN))
            settle_q <= settle_q + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst || relatch_q)
            latched_q <= 1'b0;
        else if (sampleNow)
            latched_q <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    msfm_pkg::msfm_mode_t modeDecoded;
    msfm_pkg::msfm_mode_t mode_q;
    logic [5:0]           strap_q;

    always_comb
    begin
        case (modePinsSync)
            msfm_pkg::MSFM_PAT_4HOST:   modeDecoded = msfm_pkg::MSFM_MODE_4HOST;
            msfm_pkg::MSFM_PAT_OTG:     modeDecoded = msfm_pkg::MSFM_MODE_OTG;
            msfm_pkg::MSFM_PAT_OTG_ISA: modeDecoded = msfm_pkg::MSFM_MODE_OTG_ISA;
            msfm_pkg::MSFM_PAT_OTG_GP:  modeDecoded = msfm_pkg::MSFM_MODE_OTG_GP;
            default:                    modeDecoded = msfm_pkg::MSFM_MODE_INVALID;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_q  <= msfm_pkg::MSFM_MODE_4HOST;
            strap_q <= msfm_pkg::MSFM_STRAP_RESET;
        end
        else if (sampleNow)
        begin
            mode_q  <= modeDecoded;
            strap_q <= strapPinsSync;
        end
    end

    // ----------------------------------------------------------------
    // Function map, one slot per function
    // ----------------------------------------------------------------
    logic [23:0] fnTargetD;
    logic [15:0] fnChannelD;

    genvar gi;
    generate
        for (gi = 0; gi < msfm_pkg::MSFM_NUM_FUNC; gi++)
        begin : g_func
            msfm_pkg::msfm_fn_t slotTarget;
            msfm_func_map #(
                .FUNC (gi)
            ) u_map (
                .mode    (mode_q),
                .target  (slotTarget),
                .channel (fnChannelD[gi*2 +: 2])
            );
            assign fnTargetD[gi*3 +: 3] = slotTarget;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            opMode           <= 3'h0;
            modeValid        <= 1'b0;
            funcTarget       <= 24'h0;
            funcChannel      <= 16'h0;
            latched          <= 1'b0;
        end
        else
        begin
            opMode           <= mode_q;
            modeValid        <= latched_q && (mode_q != msfm_pkg::MSFM_MODE_INVALID);
            funcTarget       <= fnTargetD;
            funcChannel      <= fnChannelD;
            latched          <= latched_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pcieErrMask      <= 1'b1;
            readSizeLimit    <= 1'b0;
            readSizeMax      <= 8'h0;
            auxPowerPresent  <= 1'b0;
            aspmEnable       <= 1'b1;
            aerEnable        <= 1'b1;
            d3ColdWakeEnable <= 1'b0;
        end
        else
        begin
            pcieErrMask      <= !strap_q[msfm_pkg::MSFM_STRAP_ERRMASK];
            readSizeLimit    <= strap_q[msfm_pkg::MSFM_STRAP_RDSIZE];
            readSizeMax      <= strap_q[msfm_pkg::MSFM_STRAP_RDSIZE] ? msfm_pkg::MSFM_RDSIZE_LIMIT : 8'h0;
            auxPowerPresent  <= strap_q[msfm_pkg::MSFM_STRAP_AUXPWR];
            aspmEnable       <= strap_q[msfm_pkg::MSFM_STRAP_ASPM];
            aerEnable        <= strap_q[msfm_pkg::MSFM_STRAP_AER];
            d3ColdWakeEnable <= !strap_q[msfm_pkg::MSFM_STRAP_HIBWAKE];
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states; pready stays high so every access ends in its first access cycle
    logic        apbWrite;
    logic        apbRead;
    logic        addrHit;
    logic [31:0] readMux;

    assign apbWrite = psel && penable && pwrite;
    assign apbRead  = psel && !penable && !pwrite;
    assign addrHit  = (paddr == msfm_pkg::MSFM_REG_MODE) || (paddr == msfm_pkg::MSFM_REG_STRAP)
                   || (paddr == msfm_pkg::MSFM_REG_FUNC) || (paddr == msfm_pkg::MSFM_REG_CTRL);

    always_comb
    begin
        readMux = 32'h0;
        case (paddr)
            msfm_pkg::MSFM_REG_MODE:  readMux = {23'h0, latched_q, 5'h0, mode_q};
            msfm_pkg::MSFM_REG_STRAP: readMux = {26'h0, strap_q};
            msfm_pkg::MSFM_REG_FUNC:  readMux = {8'h0, fnTargetD};
            msfm_pkg::MSFM_REG_CTRL:  readMux = 32'h0;
            default:                  readMux = 32'h0;
        endcase
    end

    // Re-latch is a self-clearing pulse so software can resample straps without a reset
    always_ff @(posedge clk)
    begin
        if (rst)
            relatch_q <= 1'b0;
        else
            relatch_q <= apbWrite && (paddr == msfm_pkg::MSFM_REG_CTRL) && pstrb[0]
                      && pwdata[msfm_pkg::MSFM_CTRL_RELATCH];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            if (apbRead)
                prdata <= readMux;
            if (psel && !penable)
                pslverr <= !addrHit;
            else if (!psel)
                pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    errmask_polarity_a: assert property (@(posedge clk) disable iff (rst)
        pcieErrMask == !$past(strap_q[0]))
        else $error("error mask output has wrong polarity");
    rdsize_value_a: assert property (@(posedge clk) disable iff (rst)
        readSizeLimit |-> readSizeMax == 8'h80)
        else $error("read size limit not 128 bytes");
    aux_follow_a: assert property (@(posedge clk) disable iff (rst)
        auxPowerPresent == $past(strap_q[2]))
        else $error("aux power output mismatch");
    aspm_follow_a: assert property (@(posedge clk) disable iff (rst)
        aspmEnable == $past(strap_q[3]))
        else $error("ASPM enable mismatch");
    aer_follow_a: assert property (@(posedge clk) disable iff (rst)
        aerEnable == $past(strap_q[4]))
        else $error("AER enable mismatch");
    wake_polarity_a: assert property (@(posedge clk) disable iff (rst)
        d3ColdWakeEnable == !$past(strap_q[5]))
        else $error("D3 cold wake polarity wrong");
    strap_hold_a: assert property (@(posedge clk) disable iff (rst || relatch_q)
        latched_q |=> $stable(strap_q) && $stable(mode_q))
        else $error("latched values changed");
    latch_time_a: assert property (@(posedge clk)
        $fell(rst) |-> ##[2:3] latched_q)
        else $error("latch not taken after reset");
    fixed_funcs_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> funcTarget[17:0] == 18'h08208)
        else $error("functions 0 to 5 misplaced");
    f7_isa_a: assert property (@(posedge clk) disable iff (rst)
        opMode == 3'h2 && modeValid |-> funcTarget[23:21] == 3'h3 && funcTarget[20:18] == 3'h2)
        else $error("ISA mode function 7 wrong");
    decode_gpio_a: assert property (@(posedge clk) disable iff (rst)
        modePinsSync == 5'h06 |-> modeDecoded == msfm_pkg::MSFM_MODE_OTG_GP)
        else $error("GPIO mode decode wrong");

    cov_4host_c: cover property (@(posedge clk) modeValid && opMode == 3'h0);
    cov_isa_c:   cover property (@(posedge clk) modeValid && opMode == 3'h2);
    cov_gpio_c:  cover property (@(posedge clk) modeValid && opMode == 3'h3);
    cov_wake_c:  cover property (@(posedge clk) latched && d3ColdWakeEnable);

endmodule
`default_nettype wire

// ==== msfm_board.sv ====
// Board model: mode select resistors and bootstrap pull network
`default_nettype none
module msfm_board (
    // Board configuration
    input  wire logic [4:0] pinPattern,
    input  wire logic [5:0] strapDrive,
    input  wire logic [5:0] strapOpen,
    // Mode select pins
    output logic            testEnable,
    output logic            mode_pick_bit0,
    output logic            mode_pick_bit1,
    output logic            mode_pick_bit2,
    output logic            otg_select_low,
    // Bootstrap pins
    output logic            link_status_pin0,
    output logic            link_status_pin1,
    output logic            link_status_pin2,
    output logic            gp_pin_19,
    output logic            gp_pin_20,
    output logic            gp_pin_21
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    // Link pins pulled down, GP pins pulled up inside the device
    localparam logic [5:0] PULL_DEFAULT = 6'h38;

    // Pattern order {test, sel2, sel1, sel0, otgLow}
    assign {testEnable, mode_pick_bit2, mode_pick_bit1, mode_pick_bit0, otg_select_low} = pinPattern;

    // An open strap floats to the internal pull, never to the last driven level
    assign {gp_pin_21, gp_pin_20, gp_pin_19, link_status_pin2, link_status_pin1, link_status_pin0} =
        (strapDrive & ~strapOpen) | (PULL_DEFAULT & strapOpen);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the mode strap function mapper
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, err, modeValid, latched;
    logic        testEnable, mode_pick_bit0, mode_pick_bit1, mode_pick_bit2, otg_select_low;
    logic        link_status_pin0, link_status_pin1, link_status_pin2, gp_pin_19, gp_pin_20, gp_pin_21;
    logic [4:0]  pinPattern;
    logic [5:0]  strapDrive, strapOpen;
    logic [2:0]  opMode;
    logic [23:0] funcTarget;
    logic [15:0] funcChannel;
    logic [7:0]  readSizeMax;
    logic        pcieErrMask, readSizeLimit, auxPowerPresent, aspmEnable, aerEnable, d3ColdWakeEnable;
    int          fails, checks;

    msfm_board msfm_board_inst (.pinPattern(pinPattern), .strapDrive(strapDrive), .strapOpen(strapOpen),
        .testEnable(testEnable), .mode_pick_bit0(mode_pick_bit0), .mode_pick_bit1(mode_pick_bit1),
        .mode_pick_bit2(mode_pick_bit2), .otg_select_low(otg_select_low), .link_status_pin0(link_status_pin0),
        .link_status_pin1(link_status_pin1), .link_status_pin2(link_status_pin2), .gp_pin_19(gp_pin_19),
        .gp_pin_20(gp_pin_20), .gp_pin_21(gp_pin_21));

    msfm_top msfm_top_inst (.clk(clk), .rst(rst), .testEnable(testEnable), .mode_pick_bit0(mode_pick_bit0),
        .mode_pick_bit1(mode_pick_bit1), .mode_pick_bit2(mode_pick_bit2), .otg_select_low(otg_select_low),
        .link_status_pin0(link_status_pin0), .link_status_pin1(link_status_pin1),
        .link_status_pin2(link_status_pin2), .gp_pin_19(gp_pin_19), .gp_pin_20(gp_pin_20), .gp_pin_21(gp_pin_21),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .opMode(opMode), .modeValid(modeValid),
        .funcTarget(funcTarget), .funcChannel(funcChannel), .pcieErrMask(pcieErrMask),
        .readSizeLimit(readSizeLimit), .readSizeMax(readSizeMax), .auxPowerPresent(auxPowerPresent),
        .aspmEnable(aspmEnable), .aerEnable(aerEnable), .d3ColdWakeEnable(d3ColdWakeEnable), .latched(latched));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fails++;
                finish_test();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pins are set on the same edge that reset asserts and stay put across its release
    task automatic reset_with(input logic [4:0] pat, input logic [5:0] drv, input logic [5:0] opn);
        int n;
        n = 0;
        @(posedge clk);
        pinPattern <= pat;
        strapDrive <= drv;
        strapOpen  <= opn;
        rst        <= 1'b1;
        repeat (6) @(posedge clk);
        check("reset state", 32'(7'b0001110),
              32'({pready, latched, modeValid, pcieErrMask, aspmEnable, aerEnable, d3ColdWakeEnable}));
        rst <= 1'b0;
        while (latched !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fails++;
                finish_test();
            end
            @(posedge clk);
        end
        @(posedge clk);
    endtask

    task automatic check_straps(input logic [5:0] r);
        check("strap outputs", 32'({!r[0], r[1], (r[1] ? 8'h80 : 8'h00), r[2], r[3], r[4], !r[5]}),
              32'({pcieErrMask, readSizeLimit, readSizeMax, auxPowerPresent, aspmEnable, aerEnable,
                   d3ColdWakeEnable}));
        apb(1'b0, msfm_pkg::MSFM_REG_STRAP, 32'h0);
        check("strap reg", 32'(r), rd);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_modes();
        logic [4:0]  pats [5];
        logic [2:0]  modes [5];
        logic [5:0]  hi [5];
        logic [3:0]  hiCh [5];
        logic [23:0] tgt;
        logic [15:0] mask;
        pats  = '{5'h01, 5'h02, 5'h04, 5'h06, 5'h10};
        modes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        hi    = '{{msfm_pkg::MSFM_FN_EHCI, msfm_pkg::MSFM_FN_OHCI}, {msfm_pkg::MSFM_FN_UNUSED, msfm_pkg::MSFM_FN_OTG},
                  {msfm_pkg::MSFM_FN_ISA, msfm_pkg::MSFM_FN_OTG}, {msfm_pkg::MSFM_FN_GPIO, msfm_pkg::MSFM_FN_OTG},
                  {msfm_pkg::MSFM_FN_UNUSED, msfm_pkg::MSFM_FN_UNUSED}};
        hiCh  = '{4'hf, 4'h2, 4'h2, 4'h2, 4'h0};
        for (int i = 0; i < 5; i++)
        begin
            reset_with(pats[i], 6'h01, 6'h3e);
            tgt  = {hi[i], {3{msfm_pkg::MSFM_FN_EHCI, msfm_pkg::MSFM_FN_OHCI}}};
            mask = (i == 2 || i == 3) ? 16'h3fff : 16'hffff;
            check("opMode", 32'(modes[i]), 32'(opMode));
            check("modeValid", 32'(i < 4), 32'(modeValid));
            check("funcTarget", 32'(tgt), 32'(funcTarget));
            check("funcChannel", 32'({hiCh[i], 12'ha50} & mask), 32'(funcChannel & mask));
            apb(1'b0, msfm_pkg::MSFM_REG_MODE, 32'h0);
            check("mode reg", {23'h0, 1'b1, 5'h0, modes[i]}, rd);
            apb(1'b0, msfm_pkg::MSFM_REG_FUNC, 32'h0);
            check("func reg", {8'h0, tgt}, rd);
        end
    endtask

    task automatic test_straps();
        logic [5:0] drv [4];
        logic [5:0] opn [4];
        logic [5:0] raw [4];
        drv = '{6'h01, 6'h06, 6'h2a, 6'h15};
        opn = '{6'h3e, 6'h00, 6'h00, 6'h00};
        raw = '{6'h39, 6'h06, 6'h2a, 6'h15};
        for (int i = 0; i < 4; i++)
        begin
            reset_with(5'h01, drv[i], opn[i]);
            check_straps(raw[i]);
        end
    endtask

    task automatic test_hold_relatch();
        int n;
        n = 0;
        reset_with(5'h02, 6'h15, 6'h00);
        pinPattern <= 5'h06;
        strapDrive <= 6'h2a;
        repeat (10) @(posedge clk);
        check("held mode", 32'h1, 32'(opMode));
        check_straps(6'h15);
        apb(1'b1, msfm_pkg::MSFM_REG_CTRL, 32'h1);
        while (readSizeLimit !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 20)
        begin
            fails++;
            finish_test();
        end
        check_straps(6'h2a);
        apb(1'b0, msfm_pkg::MSFM_REG_CTRL, 32'h0);
        check("ctrl reads zero", 32'h0, rd);
    endtask

    task automatic test_bus_errors();
        reset_with(5'h04, 6'h01, 6'h3e);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h010, 32'hffffffff);
        check("unmapped write", 32'h1, {31'h0, err});
        apb(1'b1, msfm_pkg::MSFM_REG_MODE, 32'h0);
        apb(1'b1, msfm_pkg::MSFM_REG_FUNC, 32'hffffffff);
        apb(1'b0, msfm_pkg::MSFM_REG_MODE, 32'h0);
        check("mode kept", 32'h102, rd);
        check("mapped ok", 32'h0, {31'h0, err});
        check("opMode kept", 32'h2, 32'(opMode));
    endtask

    initial
    begin
        rst        = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        pstrb      = 4'hf;
        pinPattern = 5'h01;
        strapDrive = 6'h01;
        strapOpen  = 6'h3e;
        fails      = 0;
        checks     = 0;
        test_modes();
        test_straps();
        test_hold_relatch();
        test_bus_errors();
        finish_test();
    end
endmodule
`default_nettype wire
